// ===== rtl/trng_defs.vh
`ifndef TRNG_DEFS_VH
`define TRNG_DEFS_VH
// Word width delivered to the consumer
`define TRG_WORD_W      32
// Total-failure test: longest run of identical raw bits tolerated
`define TRG_RUN_LIMIT   16'h0040
// Online test window length in raw bits and tolerated ones count band
`define TRG_WIN_LEN     16'h0400
`define TRG_ONES_LO     16'h01a0
`define TRG_ONES_HI     16'h0260
// Number of passing windows forming the power-up test
`define TRG_PWRUP_WINS  4'h2
// Controller states
`define TRG_ST_IDLE     2'h0
`define TRG_ST_PWRUP    2'h1
`define TRG_ST_RUN      2'h2
`define TRG_ST_HALT     2'h3
`endif

// ===== rtl/trg_gate.v
`timescale 1ns/1ps
`include "trng_defs.vh"
// What this block does
// R1 - Total-failure check runs from start, flags immediately
// R2 - After total failure, no output words
// R3 - Suppress words using bits after failure
// R4 - Online test at start-up and during operation
// R5 - No output before power-up test passes
// R6 - Online test scans every raw bit continuously
// R7 - Output words are 32 bits wide
// R8 - Sticky status for total failure and defect
module trg_gate #(
	parameter WORD_W    = `TRG_WORD_W,
	parameter RUN_LIMIT = `TRG_RUN_LIMIT,
	parameter WIN_LEN   = `TRG_WIN_LEN,
	parameter ONES_LO   = `TRG_ONES_LO,
	parameter ONES_HI   = `TRG_ONES_HI
) (
	// Clock and reset
	input  wire              CLK,
	input  wire              RESETN,
	// Control
	input  wire              START,
	input  wire              CLEAR_STATUS,
	// Raw entropy source
	input  wire              RAW_BIT,
	input  wire              RAW_VALID,
	// Consumer
	output reg  [WORD_W-1:0] RND_DATA,
	output reg               RND_VALID,
	input  wire              RND_READY,
	// Status
	output wire              READY_STAT,
	output wire              TOTAL_FAIL,
	output wire              DEFECT
);

	reg  [1:0]        state_r;
	reg  [1:0]        state_nxt;
	reg  [WORD_W-1:0] shift_r;
	reg  [5:0]        fill_r;
	wire              active;
	wire              take;
	wire              restart;
	wire              tf_hit;
	wire              win_end;
	wire              win_bad;
	wire [3:0]        passes;
	wire              fault;
	wire              word_done;

	assign active    = (state_r == `TRG_ST_PWRUP) || (state_r == `TRG_ST_RUN);
	assign take      = active && RAW_VALID; // R6
	// Idle and halt clear the run count and all window state; the run test keeps its last raw bit across a restart
	assign restart   = !active;
	assign fault     = tf_hit || win_bad;
	assign word_done = take && (fill_r == WORD_W - 1);

	// Total-failure test: flags the failing bit itself, so the word
	// holding it is never released
	trg_run_chk #(
		.LIMIT   (RUN_LIMIT)
	) trg_run_chk_inst (
		.clk     (CLK),
		.resetn  (RESETN),
		.restart (restart),
		.take    (take),
		.bit_in  (RAW_BIT),
		.hit     (tf_hit)
	); // R1

	// Online test over back-to-back windows of raw bits
	trg_win_chk #(
		.WIN_LEN (WIN_LEN),
		.ONES_LO (ONES_LO),
		.ONES_HI (ONES_HI)
	) trg_win_chk_inst (
		.clk     (CLK),
		.resetn  (RESETN),
		.restart (restart),
		.take    (take),
		.bit_in  (RAW_BIT),
		.win_end (win_end),
		.win_bad (win_bad),
		.passes  (passes)
	); // R4

	// Status flags that tell software why output stopped
	trg_sticky trg_sticky_tf_inst (
		.clk     (CLK),
		.resetn  (RESETN),
		.set     (tf_hit),
		.clear   (CLEAR_STATUS),
		.flag    (TOTAL_FAIL)
	); // R8
	trg_sticky trg_sticky_def_inst (
		.clk     (CLK),
		.resetn  (RESETN),
		.set     (win_bad),
		.clear   (CLEAR_STATUS),
		.flag    (DEFECT)
	); // R8

	assign READY_STAT = (state_r == `TRG_ST_RUN);

	always @* begin
		state_nxt = state_r;
		case (state_r)
			`TRG_ST_IDLE: begin
				if (START)
					state_nxt = `TRG_ST_PWRUP;
			end
			`TRG_ST_PWRUP: begin
				if (fault)
					state_nxt = `TRG_ST_HALT; // R5
				else if (win_end && (passes == `TRG_PWRUP_WINS - 4'h1))
					state_nxt = `TRG_ST_RUN;
			end
			`TRG_ST_RUN: begin
				if (fault)
					state_nxt = `TRG_ST_HALT; // R2
			end
			`TRG_ST_HALT: begin
				// Only a fresh start re-runs the power-up test
				if (START)
					state_nxt = `TRG_ST_PWRUP;
			end
			default: state_nxt = `TRG_ST_IDLE;
		endcase
	end

	always @(posedge CLK) begin
		if (!RESETN) begin
			state_r   <= `TRG_ST_IDLE;
			shift_r   <= {WORD_W{1'b0}};
			fill_r    <= 6'h00;
			RND_DATA  <= {WORD_W{1'b0}};
			RND_VALID <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// A partial word is dropped on halt; packing restarts with the test
			if (restart)
				fill_r <= 6'h00;
			else if (take) begin
				shift_r <= {shift_r[WORD_W-2:0], RAW_BIT};
				fill_r  <= word_done ? 6'h00 : fill_r + 6'h01;
			end
			// A word whose bits all passed is offered only while running
			if (fault || state_r != `TRG_ST_RUN)
				RND_VALID <= 1'b0; // R3 R5
			else if (word_done && !(RND_VALID && !RND_READY)) begin
				// A stalled consumer loses the newer word, never the held one
				RND_DATA  <= {shift_r[WORD_W-2:0], RAW_BIT}; // R7
				RND_VALID <= 1'b1;
			end else if (RND_READY)
				RND_VALID <= 1'b0;
		end
	end

endmodule // trg_gate

// Counts repeats of the same raw bit; a run longer than LIMIT is taken as
// a total failure of the source
module trg_run_chk #(
	parameter LIMIT = `TRG_RUN_LIMIT
) (
	// Clock and reset
	input  wire clk,
	input  wire resetn,
	// Raw bit stream
	input  wire restart,
	input  wire take,
	input  wire bit_in,
	// Result
	output wire hit
);

	reg  [15:0] run_r;
	reg         last_bit_r;
	wire        same_bit;

	assign same_bit = (bit_in == last_bit_r);
	assign hit      = take && same_bit && (run_r >= LIMIT - 16'h0001); // R1

	always @(posedge clk) begin
		if (!resetn) begin
			last_bit_r <= 1'b0;
			run_r      <= 16'h0000;
		end else if (restart)
			run_r <= 16'h0000;
		else if (take) begin
			last_bit_r <= bit_in;
			run_r      <= same_bit ? run_r + 16'h0001 : 16'h0000; // R6
		end
	end

endmodule // trg_run_chk

// Counts ones over back-to-back windows of WIN_LEN raw bits; a count
// outside the band is a defect, and each window that ends bumps a
// saturating pass count
module trg_win_chk #(
	parameter WIN_LEN = `TRG_WIN_LEN,
	parameter ONES_LO = `TRG_ONES_LO,
	parameter ONES_HI = `TRG_ONES_HI
) (
	// Clock and reset
	input  wire       clk,
	input  wire       resetn,
	// Raw bit stream
	input  wire       restart,
	input  wire       take,
	input  wire       bit_in,
	// Results
	output wire       win_end,
	output wire       win_bad,
	output wire [3:0] passes
);

	reg  [15:0] win_cnt_r;
	reg  [15:0] ones_r;
	reg  [3:0]  pass_r;
	wire [15:0] ones_fin;

	assign ones_fin = ones_r + {15'h0000, bit_in};
	assign win_end  = take && (win_cnt_r == WIN_LEN - 16'h0001);
	assign win_bad  = win_end && ((ones_fin < ONES_LO) || (ones_fin > ONES_HI)); // R4
	assign passes   = pass_r;

	always @(posedge clk) begin
		if (!resetn || restart) begin
			win_cnt_r <= 16'h0000;
			ones_r    <= 16'h0000;
			pass_r    <= 4'h0;
		end else if (take) begin
			// No gap between windows, so no raw bit escapes the test
			if (win_end) begin
				win_cnt_r <= 16'h0000;
				ones_r    <= 16'h0000;
				if (pass_r != 4'hf)
					pass_r <= pass_r + 4'h1;
			end else begin
				win_cnt_r <= win_cnt_r + 16'h0001; // R6
				ones_r    <= ones_fin;
			end
		end
	end

endmodule // trg_win_chk

// Sticky status flag; a set in the cycle of a clear wins, so no event is lost
module trg_sticky (
	// Clock and reset
	input  wire clk,
	input  wire resetn,
	// Control
	input  wire set,
	input  wire clear,
	// Flag
	output reg  flag
);

	always @(posedge clk) begin
		if (!resetn)
			flag <= 1'b0;
		else if (set)
			flag <= 1'b1; // R8
		else if (clear)
			flag <= 1'b0;
	end

endmodule // trg_sticky

// ===== sim/trg_gate_monitor.sv
`timescale 1ns/1ps
module trg_gate_monitor #(
	parameter RUN_LIMIT = 16'h0040
) (
	// Clock and reset
	input wire        CLK,
	input wire        RESETN,
	// Raw stream and control
	input wire        RAW_BIT,
	input wire        RAW_VALID,
	input wire        CLEAR_STATUS,
	// Consumer side
	input wire [31:0] RND_DATA,
	input wire        RND_VALID,
	input wire        RND_READY,
	// Status
	input wire        READY_STAT,
	input wire        TOTAL_FAIL,
	input wire        DEFECT
);
	reg [15:0] run_r;
	reg        last_r;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// Run length counted only while running, so it never exceeds the design's
	always @(posedge CLK) begin
		if (!RESETN) begin
			run_r  <= 16'h0000;
			last_r <= 1'b0;
		end else if (!READY_STAT)
			run_r <= 16'h0000;
		else if (RAW_VALID) begin
			run_r  <= (RAW_BIT == last_r) ? run_r + 16'h0001 : 16'h0001;
			last_r <= RAW_BIT;
		end
	end
	chk_fault_quiet: assert property ((TOTAL_FAIL | DEFECT) && !READY_STAT |=> !RND_VALID)
		else $error("word after fault");
	chk_run_fail: assert property (READY_STAT && RAW_VALID && RAW_BIT == last_r &&
		run_r == RUN_LIMIT |-> ##1 TOTAL_FAIL) else $error("run not flagged");
	chk_valid_run: assert property ($rose(RND_VALID) |-> READY_STAT) else $error("early word");
	chk_idle_quiet: assert property (!READY_STAT |=> !RND_VALID) else $error("word off run");
	chk_fail_halt: assert property ($rose(TOTAL_FAIL) |-> !READY_STAT) else $error("no halt");
	chk_defect_halt: assert property ($rose(DEFECT) |-> !READY_STAT) else $error("no stop");
	chk_fail_sticky: assert property (TOTAL_FAIL && !CLEAR_STATUS |=> TOTAL_FAIL)
		else $error("fail lost");
	chk_defect_sticky: assert property (DEFECT && !CLEAR_STATUS |=> DEFECT) else $error("lost");
	chk_word_hold: assert property (RND_VALID && !RND_READY |=> !RND_VALID || $stable(RND_DATA))
		else $error("word changed");
	cover property (RND_VALID && RND_READY);
	cover property ($rose(TOTAL_FAIL));
	cover property ($rose(DEFECT));
	cover property ($rose(READY_STAT));
endmodule // trg_gate_monitor
bind trg_gate trg_gate_monitor #(.RUN_LIMIT(RUN_LIMIT)) mon_inst (.CLK(CLK), .RESETN(RESETN),
	.RAW_BIT(RAW_BIT), .RAW_VALID(RAW_VALID), .CLEAR_STATUS(CLEAR_STATUS), .RND_DATA(RND_DATA),
	.RND_VALID(RND_VALID), .RND_READY(RND_READY), .READY_STAT(READY_STAT),
	.TOTAL_FAIL(TOTAL_FAIL), .DEFECT(DEFECT));

// ===== sim/trg_consumer.sv
`timescale 1ns/1ps
module trg_consumer (
	// Clock
	input  wire clk,
	// Handshake
	input  wire valid,
	output reg  ready = 1'b0
);
	reg [1:0] wait_r = 2'h0;
	integer   seed   = 68312;
	// Stall at random, but never so long that a finished word is dropped
	always @(posedge clk) begin
		wait_r <= (valid & ~ready) ? wait_r + 2'h1 : 2'h0;
		ready  <= (($random(seed) & 1) != 0) || (wait_r == 2'h3);
	end
endmodule // trg_consumer

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg CLK = 0, RESETN = 0, START = 0, CLEAR_STATUS = 0, RAW_BIT = 0, RAW_VALID = 0;
	wire [31:0] RND_DATA;
	wire RND_VALID, RND_READY, READY_STAT, TOTAL_FAIL, DEFECT;
	integer seed = 68312, n_mismatch = 0, compares = 0;
	reg [31:0] q[$];
	trg_gate #(.RUN_LIMIT(16'h0010), .WIN_LEN(16'h0040), .ONES_LO(16'h0010), .ONES_HI(16'h0030))
		trg_gate_inst (.CLK(CLK), .RESETN(RESETN), .START(START), .CLEAR_STATUS(CLEAR_STATUS),
		.RAW_BIT(RAW_BIT), .RAW_VALID(RAW_VALID), .RND_DATA(RND_DATA), .RND_VALID(RND_VALID),
		.RND_READY(RND_READY), .READY_STAT(READY_STAT), .TOTAL_FAIL(TOTAL_FAIL), .DEFECT(DEFECT));
	trg_consumer trg_consumer_inst (.clk(CLK), .valid(RND_VALID), .ready(RND_READY));
	initial forever #5 CLK = ~CLK;
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task bit1(input b); @(posedge CLK) {RAW_BIT, RAW_VALID} <= {b, 1'b1}; endtask
	task word(input [31:0] w); for (int i = 31; i >= 0; i--) bit1(w[i]); endtask
	// Random bits in complementary pairs: runs stay short and each window is balanced
	task gw(input push);
		reg [31:0] w;
		for (int i = 0; i < 16; i++) {w[2*i+1], w[2*i]} = (($random(seed) & 1) != 0) ? 2'h2 : 2'h1;
		if (push) q.push_back(w);
		word(w);
	endtask
	task go(input clr); @(posedge CLK) {START, CLEAR_STATUS} <= {1'b1, clr};
		@(posedge CLK) {START, CLEAR_STATUS} <= 2'h0; endtask
	task rest(input int n); @(posedge CLK) RAW_VALID <= 0; repeat (n) @(posedge CLK); endtask
	// An empty queue turns any delivered word into a mismatch
	always @(posedge CLK) if (RND_VALID === 1 && RND_READY === 1)
		chk("word", RND_DATA, q.size() ? q.pop_front() : ~RND_DATA);
	task wrap_up;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin #30000 n_mismatch++; wrap_up; end
	initial begin
		repeat (5) @(posedge CLK);
		RESETN <= 1;
		go(0);
		repeat (4) gw(0);
		rest(3);
		chk("ready", READY_STAT, 1);
		repeat (6) gw(1);
		// One past the longest tolerated run, whatever the last word ended with
		repeat (17) bit1(1);
		rest(40);
		chk("tfail", TOTAL_FAIL, 1);
		chk("ready", READY_STAT, 0);
		chk("left", q.size(), 0);
		$display("stream and failure test done");
		go(1);
		rest(2);
		chk("tfail", TOTAL_FAIL, 0);
		repeat (3) word(32'h80808080);
		rest(3);
		chk("defect", DEFECT, 1);
		chk("ready", READY_STAT, 0);
		$display("defect test done");
		wrap_up;
	end
endmodule // tb_top
